/* File: hw/cif_irq_flag_mask.sv */
/*
 * Charger interrupt flag and mask logic: latches fault entries and
 * charger events, gates them with the mask registers onto one interrupt
 * pulse, and serves the registers to the serial register engine.
 * Assumes status inputs come from analog/async sources (synchronised
 * here), adcDone, oneShotMode and the register port are on clk.
 */
// Operation
// - Overvoltage entry sets fault bit 7
// - Overheat shutdown entry sets fault bit 6
// - Safety timer rising edge sets bit 4
// - Reserved bits read zero, ignore writes
// - Mask A7 gates one-shot conversion done
// - Mask A6 gates input current limit entry
// - Mask A5 gates input voltage limit entry
// - Mask A4 gates thermal regulation entry
// - Mask A3 gates host timeout rising edge
// - Mask A0 gates charge phase change
// - Mask B7 gates supply good toggle
// - Mask B4 gates input source change
// - Mask B2 gates thermistor zone change
// - Mask B1 gates optimizer rising edge
// - Register reset restores; watchdog leaves alone
// - Event flags latch on rising edges, code and supply good flags on any change; conversion done sets none
// - Fault sources have own interrupt masks
`timescale 1ns/1ps

module cif_irq_flag_mask
    import cif_pkg::*;
#(
    parameter int PULSE_LEN = INT_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic regReset,
    // Register port from the serial engine
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWrData,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // Charger status, asynchronous
    input wire logic inputOvervoltage,
    input wire logic dieOverheatShutdown,
    input wire logic safetyTimerExpired,
    input wire logic inputCurrentLimitActive,
    input wire logic inputVoltageLimitActive,
    input wire logic thermalRegulationActive,
    input wire logic hostTimeoutExpired,
    input wire logic supplyGood,
    input wire logic currentOptimizerState,
    input wire logic [2:0] chargePhaseCode,
    input wire logic [2:0] inputSourceCode,
    input wire logic [2:0] thermistorZoneCode,
    // Converter, same clock
    input wire logic adcDone,
    input wire logic oneShotMode,
    // Interrupt
    output logic irqPulse
);

    // ************************************************************
    // Input synchronisers and edge detection
    // ************************************************************
    logic [SYNC_W-1:0] rawStat;
    logic [SYNC_W-1:0] syncMeta;
    logic [SYNC_W-1:0] syncStat;
    logic [SYNC_W-1:0] prevStat;
    logic [1:0] primeCnt;
    logic primed;
    logic [1:0] next_primeCnt;
    logic [SYNC_W-1:0] riseStat;
    logic [SYNC_W-1:0] diffStat;

    assign rawStat = {inputOvervoltage, dieOverheatShutdown, safetyTimerExpired, inputCurrentLimitActive,
                      inputVoltageLimitActive, thermalRegulationActive, hostTimeoutExpired, supplyGood,
                      currentOptimizerState, chargePhaseCode, inputSourceCode, thermistorZoneCode};

    // Hold off edges until the synchroniser holds real samples
    always_comb begin
        next_primeCnt = primeCnt;
        if (!primed) begin
            next_primeCnt = primeCnt + 2'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncMeta <= '0;
            syncStat <= '0;
            prevStat <= '0;
            primeCnt <= 2'h0;
        end else begin
            syncMeta <= rawStat;
            syncStat <= syncMeta;
            prevStat <= syncStat;
            primeCnt <= next_primeCnt;
        end
    end

    assign primed = (primeCnt == 2'(PRIME_CYCLES));
    assign riseStat = primed ? (syncStat & ~prevStat) : '0;
    assign diffStat = primed ? (syncStat ^ prevStat) : '0;

    // ************************************************************
    // Event vectors, laid out as the register bits
    // ************************************************************
    logic [7:0] evFault;
    logic [7:0] evA;
    logic [7:0] evB;

    always_comb begin
        evFault = 8'h00;
        evA = 8'h00;
        evB = 8'h00;
        evFault[BIT_OVP] = riseStat[S_OVP];
        evFault[BIT_DIE_OVERHEAT_SHUTDOWN] = riseStat[S_DIE_OVERHEAT_SHUTDOWN];
        evFault[BIT_TMR] = riseStat[S_TMR];
        evA[BIT_ADC] = adcDone & oneShotMode;
        evA[BIT_IIN] = riseStat[S_IIN];
        evA[BIT_VIN] = riseStat[S_VIN];
        evA[BIT_THERMAL_REGULATION_ACTIVE] = riseStat[S_THERMAL_REGULATION_ACTIVE];
        evA[BIT_WD] = riseStat[S_WD];
        evA[BIT_CHRG] = |diffStat[S_CHRG_LO +: CODE_W];
        evB[BIT_PG] = diffStat[S_PG];
        evB[BIT_SRC] = |diffStat[S_SRC_LO +: CODE_W];
        evB[BIT_TS] = |diffStat[S_TS_LO +: CODE_W];
        evB[BIT_ICO] = riseStat[S_ICO];
    end

    // ************************************************************
    // Registers, flags and interrupt pulse
    // ************************************************************
    logic [7:0] faultFlags;
    logic [7:0] chgFlagA;
    logic [7:0] chgFlagB;
    logic [7:0] maskA;
    logic [7:0] maskB;
    logic [7:0] faultMask;
    logic [7:0] irqCnt;
    logic [7:0] next_faultFlags;
    logic [7:0] next_chgFlagA;
    logic [7:0] next_chgFlagB;
    logic [7:0] next_maskA;
    logic [7:0] next_maskB;
    logic [7:0] next_faultMask;
    logic [7:0] next_regRdData;
    logic [7:0] next_irqCnt;
    logic next_irqPulse;
    logic irqTrig;

    assign irqTrig = (|(evA & ~maskA)) | (|(evB & ~maskB)) | (|(evFault & ~faultMask));

    always_comb begin
        next_faultFlags = faultFlags;
        next_chgFlagA = chgFlagA;
        next_chgFlagB = chgFlagB;
        next_maskA = maskA;
        next_maskB = maskB;
        next_faultMask = faultMask;
        next_regRdData = regRdData;
        next_irqCnt = (irqCnt != 8'h00) ? irqCnt - 8'h01 : 8'h00;
        if (regRead) begin
            case (regAddr)
                ADDR_CHG_FLAG_A: next_regRdData = chgFlagA;
                ADDR_CHG_FLAG_B: next_regRdData = chgFlagB;
                ADDR_FAULT_FLAGS: next_regRdData = faultFlags;
                ADDR_MASK_A: next_regRdData = maskA;
                ADDR_MASK_B: next_regRdData = maskB;
                ADDR_FAULT_MASK: next_regRdData = faultMask;
                default: next_regRdData = RD_UNMAPPED;
            endcase
            if (regAddr == ADDR_CHG_FLAG_A) begin
                next_chgFlagA = 8'h00;
            end
            if (regAddr == ADDR_CHG_FLAG_B) begin
                next_chgFlagB = 8'h00;
            end
            if (regAddr == ADDR_FAULT_FLAGS) begin
                next_faultFlags = 8'h00;
            end
        end
        if (regWrite) begin
            if (regAddr == ADDR_MASK_A) begin
                next_maskA = regWrData & MASK_A_BITS;
            end
            if (regAddr == ADDR_MASK_B) begin
                next_maskB = regWrData & MASK_B_BITS;
            end
            if (regAddr == ADDR_FAULT_MASK) begin
                next_faultMask = regWrData & FAULT_MASK_BITS;
            end
        end
        // new events win over a read clear
        next_faultFlags = next_faultFlags | (evFault & FAULT_BITS);
        next_chgFlagA = next_chgFlagA | (evA & FLAG_A_BITS);
        next_chgFlagB = next_chgFlagB | (evB & FLAG_B_BITS);
        if (irqTrig) begin
            next_irqCnt = 8'(PULSE_LEN);
        end
        // register reset; watchdog expiry has no path here
        if (regReset) begin
            next_faultFlags = RST_FLAGS;
            next_chgFlagA = RST_FLAGS;
            next_chgFlagB = RST_FLAGS;
            next_maskA = RST_MASK_A;
            next_maskB = RST_MASK_B;
            next_faultMask = RST_FAULT_MASK;
        end
        next_irqPulse = (next_irqCnt != 8'h00);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faultFlags <= RST_FLAGS;
            chgFlagA <= RST_FLAGS;
            chgFlagB <= RST_FLAGS;
            maskA <= RST_MASK_A;
            maskB <= RST_MASK_B;
            faultMask <= RST_FAULT_MASK;
            regRdData <= RD_UNMAPPED;
            irqCnt <= 8'h00;
            irqPulse <= 1'b0;
        end else begin
            faultFlags <= next_faultFlags;
            chgFlagA <= next_chgFlagA;
            chgFlagB <= next_chgFlagB;
            maskA <= next_maskA;
            maskB <= next_maskB;
            faultMask <= next_faultMask;
            regRdData <= next_regRdData;
            irqCnt <= next_irqCnt;
            irqPulse <= next_irqPulse;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ovp_flag_set: assert property (
        (primed && syncStat[S_OVP] && !prevStat[S_OVP] && !regReset) |=> faultFlags[BIT_OVP])
        else $error("overvoltage entry did not set its flag");
    a_die_overheat_shutdown_event_set: assert property (
        (primed && syncStat[S_DIE_OVERHEAT_SHUTDOWN] && !prevStat[S_DIE_OVERHEAT_SHUTDOWN] && !regReset) |=> faultFlags[BIT_DIE_OVERHEAT_SHUTDOWN])
        else $error("shutdown entry did not set its flag");
    a_safety_timer_expiry_event_edge: assert property (
        (!regReset && !(regRead && regAddr == ADDR_FAULT_FLAGS) && !faultFlags[BIT_TMR]
         && !(primed && syncStat[S_TMR] && !prevStat[S_TMR])) |=> !faultFlags[BIT_TMR])
        else $error("timer flag set without a rising edge");
    a_reserved_zero: assert property (
        ((faultFlags & ~FAULT_BITS) == 8'h00) && ((maskA & ~MASK_A_BITS) == 8'h00)
        && ((maskB & ~MASK_B_BITS) == 8'h00))
        else $error("reserved bit holds a one");
    a_adc_done_irq: assert property (
        (adcDone && oneShotMode && !maskA[BIT_ADC]) |=> irqPulse)
        else $error("unmasked conversion done gave no pulse");
    a_iin_irq: assert property (
        (primed && syncStat[S_IIN] && !prevStat[S_IIN] && !maskA[BIT_IIN]) |=> irqPulse)
        else $error("input current limit entry gave no pulse");
    a_vin_irq: assert property (
        (primed && syncStat[S_VIN] && !prevStat[S_VIN] && !maskA[BIT_VIN]) |=> irqPulse)
        else $error("input voltage limit entry gave no pulse");
    a_chrg_irq: assert property (
        (primed && $changed(syncStat[S_CHRG_LO +: CODE_W]) && !maskA[BIT_CHRG]) |=> irqPulse)
        else $error("charge phase change gave no pulse");
    a_pg_irq: assert property (
        (primed && $changed(syncStat[S_PG]) && !maskB[BIT_PG]) |=> irqPulse)
        else $error("supply good toggle gave no pulse");
    a_thermal_regulation_active_irq: assert property (
        (primed && syncStat[S_THERMAL_REGULATION_ACTIVE] && !prevStat[S_THERMAL_REGULATION_ACTIVE] && !maskA[BIT_THERMAL_REGULATION_ACTIVE]) |=> irqPulse)
        else $error("thermal regulation entry gave no pulse");
    a_wd_irq: assert property (
        (primed && syncStat[S_WD] && !prevStat[S_WD] && !maskA[BIT_WD]) |=> irqPulse)
        else $error("host timeout edge gave no pulse");
    a_src_irq: assert property (
        (primed && $changed(syncStat[S_SRC_LO +: CODE_W]) && !maskB[BIT_SRC]) |=> irqPulse)
        else $error("input source change gave no pulse");
    a_ts_irq: assert property (
        (primed && $changed(syncStat[S_TS_LO +: CODE_W]) && !maskB[BIT_TS]) |=> irqPulse)
        else $error("thermistor zone change gave no pulse");
    a_ico_irq: assert property (
        (primed && syncStat[S_ICO] && !prevStat[S_ICO] && !maskB[BIT_ICO]) |=> irqPulse)
        else $error("optimizer rising edge gave no pulse");
    a_ovp_irq: assert property (
        (primed && syncStat[S_OVP] && !prevStat[S_OVP] && !faultMask[BIT_OVP]) |=> irqPulse)
        else $error("unmasked overvoltage entry gave no pulse");
    a_ovp_masked: assert property (
        (primed && syncStat[S_OVP] && !prevStat[S_OVP] && faultMask[BIT_OVP] && !irqPulse && !irqTrig)
        |=> !irqPulse)
        else $error("masked overvoltage entry gave a pulse");
    a_reg_reset: assert property (
        regReset |=> (maskA == RST_MASK_A) && (maskB == RST_MASK_B) && (faultFlags == RST_FLAGS))
        else $error("register reset did not restore registers");
    a_read_clear: assert property (
        (regRead && regAddr == ADDR_FAULT_FLAGS && !regReset && evFault == 8'h00) |=> (faultFlags == 8'h00))
        else $error("fault flags not cleared after read");

endmodule

/* File: hw/cif_pkg.sv */
/*
 * Constants for the charger interrupt flag and mask block: register
 * addresses, field positions, access masks, reset values and the layout
 * of the synchronised status vector.
 * Assumes an 8-bit register address space reached from the serial
 * register engine of the device.
 */
package cif_pkg;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [7:0] ADDR_CHG_FLAG_A = 8'h0f;
    localparam logic [7:0] ADDR_CHG_FLAG_B = 8'h10;
    localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h11;
    localparam logic [7:0] ADDR_MASK_A = 8'h12;
    localparam logic [7:0] ADDR_MASK_B = 8'h13;
    localparam logic [7:0] ADDR_FAULT_MASK = 8'h14;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_MASK_A = 8'h00;
    localparam logic [7:0] RST_MASK_B = 8'h00;
    localparam logic [7:0] RST_FAULT_MASK = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ************************************************************
    // Implemented bits (others are reserved, read zero)
    // ************************************************************
    localparam logic [7:0] FAULT_BITS = 8'hd0;
    localparam logic [7:0] FAULT_MASK_BITS = 8'hd0;
    localparam logic [7:0] MASK_A_BITS = 8'hf9;
    localparam logic [7:0] MASK_B_BITS = 8'h96;
    localparam logic [7:0] FLAG_A_BITS = 8'h79;
    localparam logic [7:0] FLAG_B_BITS = 8'h96;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_OVP = 7;
    localparam int BIT_DIE_OVERHEAT_SHUTDOWN = 6;
    localparam int BIT_TMR = 4;
    localparam int BIT_ADC = 7;
    localparam int BIT_IIN = 6;
    localparam int BIT_VIN = 5;
    localparam int BIT_THERMAL_REGULATION_ACTIVE = 4;
    localparam int BIT_WD = 3;
    localparam int BIT_CHRG = 0;
    localparam int BIT_PG = 7;
    localparam int BIT_SRC = 4;
    localparam int BIT_TS = 2;
    localparam int BIT_ICO = 1;

    // ************************************************************
    // Synchronised status vector layout
    // ************************************************************
    localparam int SYNC_W = 18;
    localparam int S_OVP = 17;
    localparam int S_DIE_OVERHEAT_SHUTDOWN = 16;
    localparam int S_TMR = 15;
    localparam int S_IIN = 14;
    localparam int S_VIN = 13;
    localparam int S_THERMAL_REGULATION_ACTIVE = 12;
    localparam int S_WD = 11;
    localparam int S_PG = 10;
    localparam int S_ICO = 9;
    localparam int S_CHRG_LO = 6;
    localparam int S_SRC_LO = 3;
    localparam int S_TS_LO = 0;
    localparam int CODE_W = 3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int PRIME_CYCLES = 3;
    localparam int INT_PULSE_CYCLES = 8;

endpackage

/* File: verif/cif_host_model.sv */
/*
 * Host side model: issues register writes and reads on the parallel
 * port fed by the serial engine, one strobe cycle per access.
 * Assumes the bench supplies clk and calls one task at a time.
 */
`timescale 1ns/1ps

module cif_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic [7:0] regWrData,
    output logic regRead,
    input wire logic [7:0] regRdData
);
    // ************************************************************
    // Register access
    // ************************************************************
    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regWrData = 8'h00;
        regRead = 1'b0;
    end

    // Idle lines inverted so a stale value never looks live
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        #1;
        regAddr = a;
        regWrData = v;
        regWrite = 1'b1;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
        regAddr = ~a;
        regWrData = ~v;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        #1;
        regAddr = a;
        regRead = 1'b1;
        @(posedge clk);
        #1;
        regRead = 1'b0;
        regAddr = ~a;
        v = regRdData;
    endtask
endmodule

/* File: verif/charger_irq_flag_mask_tb_top.sv */
/*
 * Self-checking bench for the charger interrupt flag and mask block.
 * Assumes the host model drives the register port; status inputs are
 * held here for many cycles so the synchronisers always see them.
 */
`timescale 1ns/1ps

module charger_irq_flag_mask_tb_top
    import cif_pkg::*;
();
    localparam int PL = 8;
    logic clk, rst_n, regReset, adcDone, oneShotMode, irqPulse, regWrite, regRead;
    logic [7:0] regAddr, regWrData, regRdData, d, m, a, e;
    logic [SYNC_W-1:0] st;
    int badCount, nCompared, cyc, irqCnt, seed, k, j;
    int evS[12] = '{S_OVP, S_DIE_OVERHEAT_SHUTDOWN, S_TMR, S_IIN, S_VIN, S_THERMAL_REGULATION_ACTIVE, S_WD, S_CHRG_LO, S_PG, S_SRC_LO, S_TS_LO, S_ICO};
    logic [7:0] evM[12] = '{8'h14, 8'h14, 8'h14, 8'h12, 8'h12, 8'h12, 8'h12, 8'h12, 8'h13, 8'h13, 8'h13, 8'h13};
    int evB[12] = '{7, 6, 4, 6, 5, 4, 3, 0, 7, 4, 2, 1};

    cif_host_model host_u (.clk(clk), .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData),
        .regRead(regRead), .regRdData(regRdData));

    cif_irq_flag_mask #(.PULSE_LEN(PL)) dut_u (.clk(clk), .rst_n(rst_n), .regReset(regReset),
        .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead),
        .regRdData(regRdData), .inputOvervoltage(st[S_OVP]), .dieOverheatShutdown(st[S_DIE_OVERHEAT_SHUTDOWN]),
        .safetyTimerExpired(st[S_TMR]), .inputCurrentLimitActive(st[S_IIN]),
        .inputVoltageLimitActive(st[S_VIN]), .thermalRegulationActive(st[S_THERMAL_REGULATION_ACTIVE]),
        .hostTimeoutExpired(st[S_WD]), .supplyGood(st[S_PG]), .currentOptimizerState(st[S_ICO]),
        .chargePhaseCode(st[S_CHRG_LO+:3]), .inputSourceCode(st[S_SRC_LO+:3]),
        .thermistorZoneCode(st[S_TS_LO+:3]), .adcDone(adcDone), .oneShotMode(oneShotMode),
        .irqPulse(irqPulse));

    // ************************************************************
    // Helpers
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (irqPulse === 1'b1) begin
            irqCnt++;
        end
        if (cyc == 6000) begin
            badCount++;
            endOfTest();
        end
    end

    function automatic logic [7:0] bitsOf(input logic [7:0] ad);
        case (ad)
            8'h12: bitsOf = 8'hf9;
            8'h13: bitsOf = 8'h96;
            8'h14: bitsOf = 8'hd0;
            default: bitsOf = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] flagOf(input logic [7:0] ad);
        flagOf = (ad == 8'h14) ? 8'h11 : ((ad == 8'h12) ? 8'h0f : 8'h10);
    endfunction

    function automatic logic isCode(input int i);
        isCode = (i == 7) || (i == 9) || (i == 10);
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nCompared++;
        if (got !== exp) begin
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
            badCount++;
        end
    endtask

    // Codes move to a random nonzero value, so the change is never a no-op
    task automatic apply(input int i, input logic on);
        @(posedge clk);
        #1;
        if (isCode(i)) begin
            st[evS[i]+:3] = on ? (3'($random(seed)) | 3'h1) : 3'h0;
        end else begin
            st[evS[i]] = on;
        end
    endtask

    task automatic endOfTest();
        $display("compared %0d mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        seed = 47419;
        rst_n = 1'b0;
        regReset = 1'b0;
        adcDone = 1'b0;
        oneShotMode = 1'b0;
        st = '0;
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (5) @(posedge clk);
        for (j = 0; j < 10; j++) begin
            a = (j % 5 == 4) ? 8'h20 : 8'h11 + 8'(j % 5);
            m = (j < 5) ? 8'hff : 8'($random(seed));
            if (j < 5) begin
                host_u.rd(a, d);
                chk(d, 8'h00);
            end
            host_u.wr(a, m);
            host_u.rd(a, d);
            chk(d, m & bitsOf(a));
        end
        $display("register test done");
        apply(0, 1'b1);
        repeat (8) @(posedge clk);
        #1;
        regReset = 1'b1;
        @(posedge clk);
        #1;
        regReset = 1'b0;
        for (j = 0; j < 4; j++) begin
            host_u.rd(8'h11 + 8'(j), d);
            chk(d, 8'h00);
        end
        apply(0, 1'b0);
        repeat (16) @(posedge clk);
        $display("register reset test done");
        for (k = 0; k < 12; k++) begin
            for (j = 0; j < 2; j++) begin
                m = 8'($random(seed));
                m[evB[k]] = (j == 1);
                host_u.wr(evM[k], m);
                irqCnt = 0;
                e = (j == 1) ? 8'h00 : 8'(PL);
                apply(k, 1'b1);
                repeat (16) @(posedge clk);
                chk(8'(irqCnt), e);
                host_u.rd(flagOf(evM[k]), d);
                chk(d, 8'h01 << evB[k]);
                apply(k, 1'b0);
                repeat (16) @(posedge clk);
                e = (isCode(k) || k == 8) ? (8'h01 << evB[k]) : 8'h00;
                host_u.rd(flagOf(evM[k]), d);
                chk(d, e);
                host_u.rd(flagOf(evM[k]), d);
                chk(d, 8'h00);
            end
        end
        $display("event test done");
        for (j = 0; j < 3; j++) begin
            oneShotMode = (j != 1);
            host_u.wr(8'h12, (j == 2) ? 8'h80 : 8'h00);
            irqCnt = 0;
            adcDone = 1'b1;
            @(posedge clk);
            #1;
            adcDone = 1'b0;
            repeat (12) @(posedge clk);
            chk(8'(irqCnt), (j == 0) ? 8'(PL) : 8'h00);
        end
        $display("conversion test done");
        endOfTest();
    end
endmodule
